//--- test/seq_engine_model.sv
// Sequencer engine model that walks launched sequences
`timescale 1ns/1ps
module seq_engine_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic seq_start,
	input wire logic [8:0] seq_start_index,
	input wire logic seq_step_valid,
	input wire logic seq_step_last,
	output logic seq_busy,
	output logic seq_rd_en,
	output logic [8:0] seq_rd_index,
	output int steps
);
	logic [8:0] idx_q;
	logic pend_q;
	logic [2:0] wait_q;
	assign seq_rd_en = seq_busy && pend_q && wait_q == 3'h0;
	// Idle index is inverted so a stale value never looks valid
	assign seq_rd_index = seq_rd_en ? idx_q : ~idx_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seq_busy <= 1'b0;
			pend_q <= 1'b0;
			idx_q <= 9'h000;
			wait_q <= 3'h0;
			steps <= 0;
		end else if (seq_start) begin
			seq_busy <= 1'b1;
			pend_q <= 1'b1;
			idx_q <= seq_start_index;
			steps <= 0;
		end else if (seq_step_valid) begin
			steps <= steps + 1;
			seq_busy <= !seq_step_last;
			pend_q <= !seq_step_last;
			idx_q <= idx_q + 9'h001;
			wait_q <= slow ? 3'h4 : 3'h0;
		end else if (seq_rd_en) begin
			pend_q <= 1'b0;
		end else if (wait_q != 3'h0) begin
			wait_q <= wait_q - 3'h1;
		end
	end
endmodule

//--- test/seq_store_bench.sv
// Self-checking bench for the sequencer program store
`timescale 1ns/1ps
module seq_store_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [5:0] headphone_path_enable = 6'h00;
	logic [1:0] speaker_path_enable = 2'h0;
	logic slow = 1'b0;
	logic [15:0] reg_rdata;
	logic reg_rvalid, seq_busy, seq_start, seq_rd_en, seq_step_last;
	logic seq_step_valid, restore_busy;
	logic [8:0] seq_start_index, seq_rd_index;
	logic [31:0] seq_step;
	logic [31:0] rs = 32'h00011aca;
	int steps, n, failures = 0, comparisons = 0;
	logic [15:0] rq[$];
	logic [8:0] sq[$];
	int en[8] = '{0, 40, 80, 120, 160, 200, 490, 498};
	int dis[8] = '{31, 447, 455, 463, 471, 479, 487, 507};
	seq_store dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reg_rvalid, .headphone_path_enable, .speaker_path_enable,
		.seq_busy, .seq_start, .seq_start_index, .seq_rd_en, .seq_rd_index,
		.seq_step, .seq_step_last, .seq_step_valid, .restore_busy);
	seq_engine_model eng (.clk, .nrst, .slow, .seq_start, .seq_start_index,
		.seq_step_valid, .seq_step_last, .seq_busy, .seq_rd_en,
		.seq_rd_index, .steps);
	initial forever #12.5 clk = ~clk;
	// ----
	// Shared tasks
	// ----
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] v,
		input logic [31:0] e);
		comparisons++;
		if (v !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		rq.push_back(e);
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
	task automatic await(input logic v);
		for (int i = 0; i < 3000 && seq_busy !== v; i++) @(negedge clk);
		if (seq_busy !== v) begin
			chk("wait", seq_busy, v);
			complete_run();
		end
	endtask
	task automatic run_seq(input int k);
		await(1'b1);
		await(1'b0);
		chk("steps", steps, k);
	endtask
	task automatic launch(input int b, input logic v, input int e, input int k);
		sq.push_back(9'(e));
		@(negedge clk);
		if (b < 6) headphone_path_enable[b] = v;
		else speaker_path_enable[b - 6] = v;
		run_seq(k);
	endtask
	task automatic count_busy;
		for (n = 0; restore_busy === 1'b1 && n < 600; n++) @(negedge clk);
		chk("restore", n, 510);
	endtask
	always @(posedge clk) begin
		if (reg_rvalid === 1'b1) begin
			chk("rdata", reg_rdata, rq.pop_front());
		end
		if (seq_start === 1'b1) begin
			chk("start", seq_start_index, sq.pop_front());
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		count_busy();
		sq.push_back(9'h180);
		run_seq(63);
		for (int b = 0; b < 8; b++) begin
			rs = xs(rs);
			slow = rs[0];
			launch(b, 1'b1, en[b], b < 6 ? 31 : 8);
			launch(b, 1'b0, dis[b], b < 6 ? 8 : 3);
		end
		// User boot steps only; index 384 and 392 to 446 stay untouched
		for (int i = 385; i < 392; i++) begin
			rs = xs(rs);
			wr(16'(16'h3000 + 2 * i), rs[15:0]);
			rd(16'(16'h3000 + 2 * i), rs[15:0]);
		end
		wr(16'h300b, 16'hf000);
		launch(0, 1'b1, 0, 6);
		launch(0, 1'b0, 31, 8);
		rd(16'h0018, 16'h0000);
		rd(16'h33fe, 16'h0000);
		rd(16'h33fc, 16'h0000);
		rd(16'h33fb, 16'hf000);
		rd(16'h337d, 16'hf000);
		// A register restore ends with the boot sequence launched again
		sq.push_back(9'h180);
		wr(16'h0018, 16'h0001);
		count_busy();
		rd(16'h300b, 16'h0000);
		rd(16'h3302, 16'h0000);
		run_seq(63);
		repeat (4) @(negedge clk);
		complete_run();
	end
endmodule

//--- test/seq_store_sva.sv
// Port checker for the sequencer program store
`timescale 1ns/1ps
module seq_store_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic seq_busy,
	input wire logic seq_start,
	input wire logic [8:0] seq_start_index,
	input wire logic seq_rd_en,
	input wire logic [31:0] seq_step,
	input wire logic seq_step_last,
	input wire logic seq_step_valid,
	input wire logic restore_busy
);
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_rd_ans;
		reg_rd |-> ##2 reg_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("no read answer");
	property p_ctl;
		reg_rd && reg_addr == 16'h0018 |-> ##2 reg_rdata == 16'h0000;
	endproperty
	a_ctl: assert property (p_ctl)
		else $error("trigger reads nonzero");
	property p_rst;
		reg_wr && reg_addr == 16'h0018 && reg_wdata[0] |=> restore_busy;
	endproperty
	a_rst: assert property (p_rst)
		else $error("restore not begun");
	property p_gap;
		seq_start |=> !seq_start;
	endproperty
	a_gap: assert property (p_gap)
		else $error("launches too close");
	property p_held;
		seq_start |-> !$past(restore_busy) && !$past(seq_busy);
	endproperty
	a_held: assert property (p_held)
		else $error("launch while busy");
	property p_st_ans;
		seq_rd_en |-> ##2 seq_step_valid;
	endproperty
	a_st_ans: assert property (p_st_ans)
		else $error("no step answer");
	property p_last;
		seq_step_valid |-> seq_step_last == (seq_step[15:12] == 4'hf);
	endproperty
	a_last: assert property (p_last)
		else $error("end flag wrong");
	property p_idx;
		seq_start |-> seq_start_index inside {9'h000, 9'h028, 9'h050,
		9'h078, 9'h0a0, 9'h0c8, 9'h1ea, 9'h1f2, 9'h01f, 9'h1bf, 9'h1c7,
		9'h1cf, 9'h1d7, 9'h1df, 9'h1e7, 9'h1fb, 9'h180};
	endproperty
	a_idx: assert property (p_idx)
		else $error("bad start index");
	c_launch: cover property (seq_start);
	c_restore: cover property (reg_wr && reg_addr == 16'h0018);
	c_end: cover property (seq_step_valid && seq_step_last);
endmodule
bind seq_store seq_store_sva chk (.clk, .nrst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .seq_busy, .seq_start,
	.seq_start_index, .seq_rd_en, .seq_step, .seq_step_last, .seq_step_valid,
	.restore_busy);

//--- verilog/seq_store.sv
// Write sequencer program store, restore engine and launch logic
`timescale 1ns/1ps
module seq_store #(
	parameter int STEPS = seq_store_pkg::STEP_COUNT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [seq_store_pkg::HALF_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [seq_store_pkg::HALF_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [5:0] headphone_path_enable,
	input wire logic [1:0] speaker_path_enable,
	input wire logic seq_busy,
	output logic seq_start,
	output logic [seq_store_pkg::IDX_W-1:0] seq_start_index,
	input wire logic seq_rd_en,
	input wire logic [seq_store_pkg::IDX_W-1:0] seq_rd_index,
	output logic [2*seq_store_pkg::HALF_W-1:0] seq_step,
	output logic seq_step_last,
	output logic seq_step_valid,
	output logic restore_busy
);
	import seq_store_pkg::*;

	if (STEPS != STEP_COUNT) begin : g_check
		$error("seq_store: preset layout needs exactly 510 steps");
	end

	typedef enum logic {ST_RESTORE, ST_IDLE} state_t;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic [15:0] step_off;
	logic in_step;
	logic [IDX_W-1:0] host_idx;
	logic host_hi;
	logic restore_req;
	logic host_step_wr;

	assign step_off = reg_addr - STEP_BASE;
	// STEP_SPAN counts registers, two per step, so the window ends below it
	assign in_step = (reg_addr >= STEP_BASE) && (step_off < STEP_SPAN);
	assign host_idx = step_off[IDX_W:1];
	assign host_hi = ~step_off[0];
	// One-shot: nothing stores the bit, so it reads back as zero
	assign restore_req = reg_wr && reg_addr == REG_RESTORE
		&& reg_wdata[RESTORE_BIT];

	// ------------------------------------------------------------
	// Restore engine
	// ------------------------------------------------------------
	state_t state_q, state_d;
	logic [IDX_W-1:0] rst_idx_q, rst_idx_d;
	logic restoring;
	logic rst_done;
	logic rst_is_last;

	assign restoring = state_q == ST_RESTORE;
	assign rst_done = restoring && rst_idx_q == IDX_W'(STEPS - 1);
	// The restore walks every index, so undefined ranges come back as zero
	always_comb begin
		rst_is_last = 1'b0;
		for (int s = 0; s < NUM_SEQ; s++) begin
			if (rst_idx_q == SEQ_LAST[s]) begin
				rst_is_last = 1'b1;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		rst_idx_d = rst_idx_q;
		unique case (state_q)
			ST_RESTORE: begin
				rst_idx_d = rst_idx_q + 9'h001;
				if (rst_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
			end
		endcase
		if (restore_req) begin
			state_d = ST_RESTORE;
			rst_idx_d = '0;
		end
	end

	// Power-on reset is nrst; other resets never reach this block
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_RESTORE;
			rst_idx_q <= '0;
		end else begin
			state_q <= state_d;
			rst_idx_q <= rst_idx_d;
		end
	end

	// ------------------------------------------------------------
	// Memory write and read ports
	// ------------------------------------------------------------
	logic [IDX_W-1:0] w_idx;
	logic we_hi, we_lo;
	logic [HALF_W-1:0] wd_hi, wd_lo;
	logic [HALF_W-1:0] host_rd_hi, host_rd_lo, seq_rd_hi, seq_rd_lo;

	// Host step writes are dropped while a restore runs
	assign host_step_wr = reg_wr && in_step && !restoring;
	assign w_idx = restoring ? rst_idx_q : host_idx;
	assign we_hi = restoring || (host_step_wr && host_hi);
	assign we_lo = restoring || (host_step_wr && !host_hi);
	assign wd_hi = restoring ? STEP_HI_RESET : reg_wdata;
	assign wd_lo = restoring ? (rst_is_last ? STEP_LO_LAST : STEP_LO_RESET)
		: reg_wdata;

	step_memory #(.WIDTH(HALF_W), .DEPTH(STEPS), .AW(IDX_W)) u_hi (
		.clk(clk),
		.we(we_hi),
		.waddr(w_idx),
		.wdata(wd_hi),
		.ra_addr(host_idx),
		.ra_data(host_rd_hi),
		.rb_addr(seq_rd_index),
		.rb_data(seq_rd_hi)
	);

	step_memory #(.WIDTH(HALF_W), .DEPTH(STEPS), .AW(IDX_W)) u_lo (
		.clk(clk),
		.we(we_lo),
		.waddr(w_idx),
		.wdata(wd_lo),
		.ra_addr(host_idx),
		.ra_data(host_rd_lo),
		.rb_addr(seq_rd_index),
		.rb_data(seq_rd_lo)
	);

	// ------------------------------------------------------------
	// Read pipelines: request, memory register, output register
	// ------------------------------------------------------------
	logic rd_q, rd_step_q, rd_hi_q;
	logic srd_q;
	logic [HALF_W-1:0] host_word;
	logic [HALF_W-1:0] reg_rdata_d;
	logic seq_last_d;

	assign host_word = rd_hi_q ? host_rd_hi : host_rd_lo;
	assign reg_rdata_d = rd_step_q ? host_word : READ_ZERO;
	assign seq_last_d =
		seq_rd_lo[DELAY_LSB+3:DELAY_LSB] == DELAY_END;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 1'b0;
			rd_step_q <= 1'b0;
			rd_hi_q <= 1'b0;
			srd_q <= 1'b0;
			reg_rvalid <= 1'b0;
			reg_rdata <= '0;
			seq_step_valid <= 1'b0;
			seq_step <= '0;
			seq_step_last <= 1'b0;
		end else begin
			rd_q <= reg_rd;
			rd_step_q <= reg_rd && in_step;
			rd_hi_q <= host_hi;
			srd_q <= seq_rd_en;
			reg_rvalid <= rd_q;
			reg_rdata <= rd_q ? reg_rdata_d : READ_ZERO;
			seq_step_valid <= srd_q;
			seq_step <= {seq_rd_hi, seq_rd_lo};
			seq_step_last <= srd_q && seq_last_d;
		end
	end

	// ------------------------------------------------------------
	// Launch requests from path enables and boot
	// ------------------------------------------------------------
	logic [NUM_PATHS-1:0] path_en, path_en_q;
	logic [NUM_SEQ-1:0] pend_q, pend_d, pend_set, grant;
	logic launch_ok;
	logic [IDX_W-1:0] grant_idx;

	assign path_en = {speaker_path_enable, headphone_path_enable};

	// Each path turns an enable edge into a pending launch
	for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
		assign pend_set[p] = path_en[p] && !path_en_q[p];
		assign pend_set[p+NUM_PATHS] = !path_en[p] && path_en_q[p];
	end
	// Boot runs once any restore, power-on or register, has filled the store
	assign pend_set[BOOT_SEQ] = rst_done && !restore_req;

	// Waiting out the restore keeps the sequencer off half-filled steps
	assign launch_ok = !restoring && !seq_busy && !seq_start;

	always_comb begin
		grant = '0;
		grant_idx = '0;
		for (int s = NUM_SEQ - 1; s >= 0; s--) begin
			if (pend_q[s] && launch_ok) begin
				grant = '0;
				grant[s] = 1'b1;
				grant_idx = SEQ_START[s];
			end
		end
	end

	// A new edge in the granting cycle is kept: set beats clear
	assign pend_d = (pend_q & ~grant) | pend_set;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			path_en_q <= '0;
			pend_q <= '0;
			seq_start <= 1'b0;
			seq_start_index <= '0;
			restore_busy <= 1'b1;
		end else begin
			path_en_q <= path_en;
			pend_q <= pend_d;
			seq_start <= |grant;
			seq_start_index <= (|grant) ? grant_idx : seq_start_index;
			restore_busy <= state_d == ST_RESTORE;
		end
	end

endmodule

//--- verilog/seq_store_pkg.sv
// Constants for the write sequencer program store
// What this block does
// - The store holds 510 step entries addressed by index 0 to 509.
// - After power-on reset the boot and output-path presets are loaded.
// - Hardware reset, software reset and sleep leave entries unchanged.
// - Presets may be overwritten; path enables still launch fixed starts.
// - Writing one to bit 0 at 0018h restores the power-on contents.
// - The boot sequence begins at index 384.
// - Headphone enables start at 0,40,80,120,160,200, 31 entries each.
// - Headphone disables start at 31,447,455,463,471,479, 8 each.
// - Speaker L en 490-497, dis 487-489; R en 498-505, dis 507-509.
// - A step with delay code all ones is the last of its sequence.
package seq_store_pkg;

	// ------------------------------------------------------------
	// Geometry and register map
	// ------------------------------------------------------------
	localparam int STEP_COUNT = 510;
	localparam int IDX_W = 9;
	localparam int HALF_W = 16;
	localparam logic [15:0] REG_RESTORE = 16'h0018;
	localparam int RESTORE_BIT = 0;
	localparam logic [15:0] STEP_BASE = 16'h3000;
	localparam logic [15:0] STEP_SPAN = 16'h03fc;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// ------------------------------------------------------------
	// Step word layout (second register of each step)
	// ------------------------------------------------------------
	localparam int DELAY_LSB = 12;
	localparam logic [3:0] DELAY_END = 4'hf;
	localparam logic [15:0] STEP_HI_RESET = 16'h0000;
	localparam logic [15:0] STEP_LO_RESET = 16'h0000;
	localparam logic [15:0] STEP_LO_LAST = 16'hf000;

	// ------------------------------------------------------------
	// Preset sequences: 0-5 hp enable, 6-7 spk enable,
	// 8-13 hp disable, 14-15 spk disable, 16 boot
	// ------------------------------------------------------------
	localparam int NUM_PATHS = 8;
	localparam int NUM_SEQ = 17;
	localparam int BOOT_SEQ = 16;
	localparam logic [IDX_W-1:0] SEQ_START [NUM_SEQ] = '{
		9'h000, 9'h028, 9'h050, 9'h078, 9'h0a0, 9'h0c8,
		9'h1ea, 9'h1f2,
		9'h01f, 9'h1bf, 9'h1c7, 9'h1cf, 9'h1d7, 9'h1df,
		9'h1e7, 9'h1fb,
		9'h180};
	localparam logic [IDX_W-1:0] SEQ_LAST [NUM_SEQ] = '{
		9'h01e, 9'h046, 9'h06e, 9'h096, 9'h0be, 9'h0e6,
		9'h1f1, 9'h1f9,
		9'h026, 9'h1c6, 9'h1ce, 9'h1d6, 9'h1de, 9'h1e6,
		9'h1e9, 9'h1fd,
		9'h1be};

endpackage

//--- verilog/step_memory.sv
// Two-read-port step store with registered read data
`timescale 1ns/1ps
module step_memory #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 510,
	parameter int AW = 9
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] ra_addr,
	output logic [WIDTH-1:0] ra_data,
	input wire logic [AW-1:0] rb_addr,
	output logic [WIDTH-1:0] rb_data
);

	if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_check
		$error("step_memory depth does not fit the address width");
	end

	// No reset on the array: contents must outlive every reset but power-on
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we && waddr < AW'(DEPTH)) begin
			mem[waddr] <= wdata;
		end
		ra_data <= mem[ra_addr];
		rb_data <= mem[rb_addr];
	end

endmodule
